// ===== inc/dp_slave_consts.svh
// Constants for the fieldbus slave state machine
`ifndef DP_SLAVE_CONSTS_SVH
`define DP_SLAVE_CONSTS_SVH

// Highest legal station address
`define DP_ADDR_MAX        7'h7D
// Telegram type codes seen on the request port
`define DP_TEL_PARAM       2'h1
`define DP_TEL_CONFIG      2'h2
`define DP_TEL_DATA        2'h3
// Standard part of a parametrizing telegram, in bytes
`define DP_PARAM_STD_BYTES 8'h07
// Reset value of the module selection
`define DP_CFG_RESET       8'h00

`endif

// ===== inc/dp_slave_pkg.sv
// Types for the fieldbus slave state machine
package dp_slave_pkg;

   // Slave communication states
   typedef enum logic [1:0] {
      SEARCH_BAUD  = 2'b00,
      AWAIT_PARAM  = 2'b01,
      AWAIT_CONFIG = 2'b10,
      DATA_EXCHG   = 2'b11
   } dp_state_t;

   // One decoded telegram from the bus receiver
   typedef struct packed {
      logic [1:0]  kind;      // Telegram type
      logic [6:0]  dest;      // Destination station address
      logic [15:0] ident;     // Ident number carried by a parametrizing telegram
      logic [7:0]  length;    // Byte count of the telegram body
      logic [7:0]  modules;   // Module selection bits from a configuration
   } dp_req_t;

   // Whole state of the slave
   typedef struct packed {
      dp_state_t   state;
      logic        addrTaken;
      logic [6:0]  stationAddr;
      logic [7:0]  moduleSel;
      logic        txStart;
      logic        online;
   } dp_slave_state_t;

endpackage

// ===== hw/dp_slave_fsm.sv
// Fieldbus slave communication state machine
//
// How it works
// - Find baud rate before any communication
// - Awaiting parameters, accept only parametrizing telegrams
// - Evaluate only the standard parameter part
// - Configuration sets count and kind of data
// - Any module mix, one 8-bit selection taken whole
// - Transmit only in answer to master
// - Station address 0..125 plus ident number
// - Address switches sampled once after reset
`include "dp_slave_consts.svh"

module dp_slave_fsm #(
   parameter logic [15:0] IDENT_NUMBER = 16'h1234,   // Arbitrary value
   parameter int          CHANNELS     = 2
) (
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      sys_rst,
   // Bus receiver side
   input  wire logic                      baudLocked,
   input  wire logic                      reqValid,
   input  wire dp_slave_pkg::dp_req_t     req,
   // Address switches
   input  wire logic [6:0]                addrSwitch,
   // Drive side
   output logic                           txStart,
   output logic [7:0]                     moduleSel,
   output logic                           online,
   output logic [6:0]                     stationAddr,
   output dp_slave_pkg::dp_state_t        state
);

   // ****************************************
   // State registers
   // ****************************************
   dp_slave_pkg::dp_slave_state_t cur;       // Registered state
   dp_slave_pkg::dp_slave_state_t next_cur;  // Next state
   logic                          forMe;     // Telegram addressed here
   logic                          paramHit;  // Addressed parametrizing telegram
   logic                          configHit; // Addressed configuration telegram
   logic                          dataHit;   // Addressed cyclic data request
   logic                          paramGood; // Parametrization passing the standard checks

   // ****************************************
   // Telegram decoding
   // ****************************************
   // True when an addressed telegram of the wanted kind is on the port
   function automatic logic tel_hit(input logic       hereNow,
                                    input logic [1:0] kindSeen,
                                    input logic [1:0] kindWanted);
      tel_hit = hereNow && (kindSeen == kindWanted);
   endfunction

   // Addressed telegram check; nothing is heard before the address is sampled
   assign forMe = reqValid && cur.addrTaken && (req.dest == cur.stationAddr);
   // Kind decode, shared by every state except SEARCH_BAUD
   assign paramHit  = tel_hit(forMe, req.kind, `DP_TEL_PARAM);
   assign configHit = tel_hit(forMe, req.kind, `DP_TEL_CONFIG);
   assign dataHit   = tel_hit(forMe, req.kind, `DP_TEL_DATA);
   // Only the standard part and the ident number decide; extra bytes are ignored
   assign paramGood = paramHit && (req.length >= `DP_PARAM_STD_BYTES)
                      && (req.ident == IDENT_NUMBER);

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      next_cur         = cur;
      next_cur.txStart = 1'b0;
      // Address caught once after reset, clipped to legal range
      if (!cur.addrTaken) begin
         next_cur.addrTaken   = 1'b1;
         next_cur.stationAddr = (addrSwitch > `DP_ADDR_MAX) ? `DP_ADDR_MAX
                                                            : addrSwitch;
      end
      case (cur.state)
         dp_slave_pkg::SEARCH_BAUD: begin
            // Nothing is taken until the baud rate is known
            if (baudLocked && cur.addrTaken) begin
               next_cur.state = dp_slave_pkg::AWAIT_PARAM;
            end
         end
         dp_slave_pkg::AWAIT_PARAM: begin
            // Only parametrizing telegrams; standard part and ident checked
            if (paramGood) begin
               next_cur.state   = dp_slave_pkg::AWAIT_CONFIG;
               next_cur.txStart = 1'b1;
            end
         end
         dp_slave_pkg::AWAIT_CONFIG: begin
            // Configuration picks any module mix, taken whole as one byte
            if (configHit) begin
               next_cur.moduleSel = req.modules;
               next_cur.state     = dp_slave_pkg::DATA_EXCHG;
               next_cur.online    = 1'b1;
               next_cur.txStart   = 1'b1;
            end else if (paramHit) begin
               // A repeated parametrization is answered, the state is kept
               next_cur.txStart = 1'b1;
            end
         end
         default: begin
            // Cyclic exchange: answer each data request
            if (dataHit) begin
               next_cur.txStart = 1'b1;
            end else if (paramHit) begin
               // Renewed parametrization drops back to the configuration wait
               next_cur.state  = dp_slave_pkg::AWAIT_CONFIG;
               next_cur.online = 1'b0;
               next_cur.txStart = 1'b1;
            end
         end
      endcase
      // Lost baud lock sends the slave back to searching
      if (!baudLocked) begin
         next_cur.state   = dp_slave_pkg::SEARCH_BAUD;
         next_cur.online  = 1'b0;
         next_cur.txStart = 1'b0;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cur <= '{state: dp_slave_pkg::SEARCH_BAUD, addrTaken: 1'b0,
                  stationAddr: 7'h00, moduleSel: `DP_CFG_RESET,
                  txStart: 1'b0, online: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs straight from flip-flops
   assign txStart     = cur.txStart;
   assign moduleSel   = cur.moduleSel;
   assign online      = cur.online;
   assign stationAddr = cur.stationAddr;
   assign state       = cur.state;

   // ****************************************
   // Assertions
   // ****************************************
   // A transmission always answers a telegram taken one cycle before
   a_tx_only_answer: assert property (@(posedge ref_clk) disable iff (sys_rst)
      txStart |-> $past(reqValid))
      else $error("Transmit started without a request");
   // The answered telegram carried this station's address
   a_tx_addressed: assert property (@(posedge ref_clk) disable iff (sys_rst)
      txStart |-> $past(req.dest) == stationAddr)
      else $error("Answer to a telegram for another station");
   // No answer while the baud rate is still searched
   a_search_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cur.state == dp_slave_pkg::SEARCH_BAUD |-> !txStart)
      else $error("Transmit during baud search");
   // Lost lock always lands in the search state
   a_baud_first: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !baudLocked |=> cur.state == dp_slave_pkg::SEARCH_BAUD)
      else $error("Left baud search unlocked");
   // Search only ever leads to the parameter wait
   a_search_exit: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cur.state == dp_slave_pkg::SEARCH_BAUD) ##1 (cur.state != $past(cur.state))
      |-> cur.state == dp_slave_pkg::AWAIT_PARAM)
      else $error("Search left to a later state");
   // Parameter wait only leads on to configuration or back to search
   a_no_skip_state: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cur.state == dp_slave_pkg::AWAIT_PARAM) ##1 (cur.state != $past(cur.state))
      |-> cur.state inside {dp_slave_pkg::AWAIT_CONFIG, dp_slave_pkg::SEARCH_BAUD})
      else $error("State skipped");
   // Configuration wait only leads on to exchange or back to search
   a_cfg_exit: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cur.state == dp_slave_pkg::AWAIT_CONFIG) ##1 (cur.state != $past(cur.state))
      |-> cur.state inside {dp_slave_pkg::DATA_EXCHG, dp_slave_pkg::SEARCH_BAUD})
      else $error("Configuration wait left wrongly");
   // Other telegram kinds never end the parameter wait
   a_param_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cur.state == dp_slave_pkg::AWAIT_PARAM && !(reqValid && req.kind == `DP_TEL_PARAM))
      |=> cur.state != dp_slave_pkg::AWAIT_CONFIG)
      else $error("Left parameter wait without parametrization");
   // A good parametrization is answered and moves the machine on
   a_param_answered: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cur.state == dp_slave_pkg::AWAIT_PARAM && paramGood && baudLocked)
      |=> (txStart && cur.state == dp_slave_pkg::AWAIT_CONFIG))
      else $error("Good parametrization not taken");
   // A telegram shorter than the standard part is refused
   a_short_param: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cur.state == dp_slave_pkg::AWAIT_PARAM && req.length < `DP_PARAM_STD_BYTES)
      |=> cur.state != dp_slave_pkg::AWAIT_CONFIG)
      else $error("Short parametrization accepted");
   // A foreign ident number is refused
   a_ident_check: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cur.state == dp_slave_pkg::AWAIT_PARAM && reqValid && req.ident != IDENT_NUMBER)
      |=> cur.state != dp_slave_pkg::AWAIT_CONFIG)
      else $error("Foreign ident number accepted");
   // Going on line takes the module mix of the configuration
   a_modules_taken: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(online) |-> moduleSel == $past(req.modules))
      else $error("Module selection not taken");
   // The module mix only changes on an accepted configuration
   a_modules_held: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !(cur.state == dp_slave_pkg::AWAIT_CONFIG && configHit) |=> $stable(moduleSel))
      else $error("Module selection changed without configuration");
   // On line only straight from the configuration wait
   a_online_needs_cfg: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(online) |-> $past(cur.state) == dp_slave_pkg::AWAIT_CONFIG)
      else $error("Online without configuration");
   // The on-line flag follows the exchange state exactly
   a_online_state: assert property (@(posedge ref_clk) disable iff (sys_rst)
      online == (cur.state == dp_slave_pkg::DATA_EXCHG))
      else $error("Online flag out of step with state");
   // Every addressed data request in exchange is answered
   a_data_answered: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cur.state == dp_slave_pkg::DATA_EXCHG && dataHit && baudLocked) |=> txStart)
      else $error("Data request not answered");
   // The sampled address stays inside the legal range
   a_addr_range: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cur.addrTaken |-> cur.stationAddr <= `DP_ADDR_MAX)
      else $error("Station address out of range");
   // Once sampled, the address holds until the next reset
   a_addr_frozen: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cur.addrTaken ##1 1'b1 |-> $stable(cur.stationAddr))
      else $error("Station address changed");

endmodule

// ===== tb/dp_master_model.sv
// Bus master model that hands decoded telegrams to the slave
module dp_master_model (
   // Clock
   input  wire logic                  ref_clk,
   // Request side
   output logic                       reqValid,
   output dp_slave_pkg::dp_req_t      req
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle lines at time zero
   initial begin
      reqValid = 1'b0;
      req      = '0;
   end

   // A request is only ever made on demand, never by the slave
   // Strobe for one cycle, then scramble the released lines
   task automatic send(input logic [1:0] k, input logic [6:0] d, input logic [15:0] id,
                       input logic [7:0] len, input logic [7:0] m);
      @(negedge ref_clk);
      reqValid = 1'b1;
      req      = '{k, d, id, len, m};
      @(negedge ref_clk);
      reqValid = 1'b0;
      req      = ~req;
   endtask
endmodule

// ===== tb/fieldbus_slave_state_machine_test.sv
// Self-checking bench for the fieldbus slave state machine
`include "dp_slave_consts.svh"
module fieldbus_slave_state_machine_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************
   // Signals
   // ****************
   localparam logic [15:0] ID = 16'h1234;     // Arbitrary value, handed to the design
   logic                    ref_clk, sys_rst, baudLocked, reqValid, txStart, online;
   logic [6:0]              addrSwitch, stationAddr;
   logic [7:0]              moduleSel;
   dp_slave_pkg::dp_req_t   req;
   dp_slave_pkg::dp_state_t state;
   int                      errTotal = 0;
   int                      checks = 0;

   dp_slave_fsm #(.IDENT_NUMBER(ID)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .baudLocked(baudLocked), .reqValid(reqValid), .req(req), .addrSwitch(addrSwitch),
      .txStart(txStart),
      .moduleSel(moduleSel), .online(online), .stationAddr(stationAddr), .state(state));
   dp_master_model mst (.ref_clk(ref_clk), .reqValid(reqValid), .req(req));

   // ****************
   // Helpers
   // ****************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         errTotal++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Reset for 5 cycles, then let the address sample land
   task automatic do_reset();
      @(negedge ref_clk);
      sys_rst = 1'b1;
      repeat (5) @(negedge ref_clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask
   // Send one telegram and judge txStart and state in the answer cycle
   task automatic tel(input logic [1:0] k, input logic [6:0] d, input logic [15:0] id,
                      input logic [7:0] len, input logic [7:0] m, input logic [7:0] exp);
      mst.send(k, d, id, len, m);
      chk({5'h00, txStart, state}, exp, "tx and state");
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      addrSwitch = 7'h7F;
      do_reset();
      chk(8'(stationAddr), 8'(`DP_ADDR_MAX), "addr clip");
      chk({4'h0, online, 1'b0, state}, 8'h00, "reset outs");
      addrSwitch = 7'h05;
      repeat (3) @(negedge ref_clk);
      chk(8'(stationAddr), 8'(`DP_ADDR_MAX), "addr held");
      do_reset();
      chk(8'(stationAddr), 8'h05, "addr new");
      $display("t_reset done");
   endtask
   task automatic t_order();
      tel(`DP_TEL_PARAM, 7'h05, ID, 8'h07, 8'h00, 8'h00);
      baudLocked = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(8'(state), 8'h01, "to param");
      tel(`DP_TEL_CONFIG, 7'h05, ID, 8'h07, 8'hA5, 8'h01);
      tel(`DP_TEL_DATA, 7'h05, ID, 8'h07, 8'hA5, 8'h01);
      tel(`DP_TEL_PARAM, 7'h05, ID, 8'h06, 8'h00, 8'h01);
      tel(`DP_TEL_PARAM, 7'h05, ~ID, 8'h07, 8'h00, 8'h01);
      tel(`DP_TEL_PARAM, 7'h06, ID, 8'h07, 8'h00, 8'h01);
      tel(`DP_TEL_PARAM, 7'h05, ID, 8'h07, 8'h00, 8'h06);
      tel(`DP_TEL_DATA, 7'h05, ID, 8'h07, 8'h00, 8'h02);
      tel(`DP_TEL_CONFIG, 7'h05, ID, 8'h07, 8'hA5, 8'h07);
      chk(moduleSel, 8'hA5, "modules");
      chk(8'(online), 8'h01, "online");
      tel(`DP_TEL_DATA, 7'h05, ID, 8'h07, 8'h00, 8'h07);
      @(negedge ref_clk);
      chk({5'h00, txStart, state}, 8'h03, "tx one cycle");
      tel(`DP_TEL_PARAM, 7'h05, ID, 8'h07, 8'h00, 8'h06);
      tel(`DP_TEL_CONFIG, 7'h05, ID, 8'h07, 8'h3C, 8'h07);
      chk(moduleSel, 8'h3C, "new mix");
      baudLocked = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk({4'h0, online, 1'b0, state}, 8'h00, "baud lost");
      $display("t_order done");
   endtask

   // ****************
   // Run control
   // ****************
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, errTotal);
      if (errTotal == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Clock, 8 ns period
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Watchdog, well past the roughly 50 cycles the tests need
   initial begin
      repeat (2000) @(posedge ref_clk);
      errTotal++;
      close_out();
   end
   // Main sequence
   initial begin
      sys_rst    = 1'b1;
      baudLocked = 1'b0;
      addrSwitch = 7'h7F;
      t_reset();
      t_order();
      close_out();
   end
endmodule
